// ==== tmrc_regs.vh ====
`ifndef TMRC_REGS_VH
`define TMRC_REGS_VH

// Register byte addresses on the APB (one aligned word each)
`define TMRC_ADDR_SC 8'h00
`define TMRC_ADDR_CNTH 8'h04
`define TMRC_ADDR_CNTL 8'h08
`define TMRC_ADDR_MODH 8'h0c
`define TMRC_ADDR_MODL 8'h10

// Status/control field positions
`define TMRC_SC_OVF 7
`define TMRC_SC_OVIE 6
`define TMRC_SC_CPWM 5
`define TMRC_SC_CLKS_HI 4
`define TMRC_SC_CLKS_LO 3
`define TMRC_SC_PS_HI 2
`define TMRC_SC_PS_LO 0

// Clock source encodings
`define TMRC_CLK_NONE 2'h0
`define TMRC_CLK_BUS 2'h1
`define TMRC_CLK_FIXED 2'h2
`define TMRC_CLK_EXT 2'h3

// Reset values
`define TMRC_SC_RESET 8'h00
`define TMRC_MOD_RESET 16'h0000
`define TMRC_CNT_RESET 16'h0000

// Counter end values
`define TMRC_CNT_TOP 16'hffff
`define TMRC_CNT_PRETOP 16'hfffe

`endif

// ==== tmrc_timer_counter_regs.v ====
`timescale 1ns/100ps
`include "tmrc_regs.vh"

module tmrc_timer_counter_regs (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Count clocks and debug
   input wire fixedFreqClock,
   input wire externalCountClock,
   input wire debugHaltMode,
   // Timer outputs
   output wire overflowIrq,
   output wire [15:0] counterValue,
   output wire countingDown,
   output wire centerAlignSelect
);

   ////////////////////////////////////////////////////////////////////////
   // Bus decode: zero wait states, every access completes in one cycle
   // Only the low byte of each word carries a register; the upper
   // bytes read as zero and are ignored on writes. Offsets outside the
   // five registers answer with an error and have no side effect, so a
   // stray access cannot arm the flag clear or disturb either latch.

   wire access = psel & penable;
   wire wrStb = access & pwrite;
   wire rdStb = access & ~pwrite;
   wire hitSc = (paddr == `TMRC_ADDR_SC);
   wire hitCntH = (paddr == `TMRC_ADDR_CNTH);
   wire hitCntL = (paddr == `TMRC_ADDR_CNTL);
   wire hitModH = (paddr == `TMRC_ADDR_MODH);
   wire hitModL = (paddr == `TMRC_ADDR_MODL);
   wire mapped = hitSc | hitCntH | hitCntL | hitModH | hitModL;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped; // Unmapped offsets are errors

   wire scWr = wrStb & hitSc;
   wire cntWr = wrStb & (hitCntH | hitCntL);
   wire cntRd = rdStb & (hitCntH | hitCntL);
   wire modWrH = wrStb & hitModH;
   wire modWrL = wrStb & hitModL;

   ////////////////////////////////////////////////////////////////////////
   // Control register state

   reg ovfFlag_q;
   reg ovfArmed_q;
   reg ovfIrqEn_q;
   reg cpwm_q;
   reg [1:0] clkSel_q;
   reg [2:0] psSel_q;
   reg [15:0] count_q;
   reg [15:0] count_d;
   reg dirDown_q;
   reg [15:0] mod_q;
   reg [15:0] modBuf_q;
   reg modGotH_q;
   reg modGotL_q;
   reg [15:0] rdLatch_q;
   reg [15:0] cntSnap_q;
   reg rdLatched_q;
   reg rdGotH_q;
   reg [6:0] preCnt_q;
   reg [2:0] fixSync_q;
   reg [2:0] extSync_q;

   assign centerAlignSelect = cpwm_q;
   assign counterValue = count_q;
   assign countingDown = dirDown_q;
   assign overflowIrq = ovfFlag_q & ovfIrqEn_q;

   ////////////////////////////////////////////////////////////////////////
   // Clock source selection and prescaler

   // Two-stage sync then rising-edge detect on the stable pair only
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fixSync_q <= 3'h0;
         extSync_q <= 3'h0;
      end else begin
         fixSync_q <= {fixSync_q[1:0], fixedFreqClock};
         extSync_q <= {extSync_q[1:0], externalCountClock};
      end
   end

   // Edge pulses; external must be slow enough to be sampled
   wire fixTick = fixSync_q[1] & ~fixSync_q[2];
   wire extTick = extSync_q[1] & ~extSync_q[2];

   reg srcTick;
   // Source mux: 00 leaves the counter stopped
   always @* begin
      case (clkSel_q)
         `TMRC_CLK_NONE: srcTick = 1'b0;
         `TMRC_CLK_BUS: srcTick = 1'b1;
         `TMRC_CLK_FIXED: srcTick = fixTick;
         `TMRC_CLK_EXT: srcTick = extTick;
         default: srcTick = 1'b0;
      endcase
   end

   // Divide mask from the live prescale field, so new value acts next cycle
   // The divider is not cleared on a prescale change: the first divided
   // tick after a change may come early, a trade for a simpler counter.
   wire [6:0] preMask = (7'h01 << psSel_q) - 7'h01;
   wire preHit = ((preCnt_q & preMask) == preMask);
   wire run = ~debugHaltMode;
   wire countEn = srcTick & preHit & run;

   // Prescale counter advances on each selected source tick unless halted in debug
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         preCnt_q <= 7'h00;
      end else if (srcTick && run) begin
         preCnt_q <= preCnt_q + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter stepping

   // Zero modulo means free run across the full range
   // An all-ones modulo gives the same count range, as it should.
   wire [15:0] topVal = (mod_q == 16'h0000) ? `TMRC_CNT_TOP : mod_q;
   wire modPending = modGotH_q & modGotL_q;
   wire atTop = (count_q == topVal);
   reg wrapEvt;
   reg dirDown_d;

   // Up count wraps to zero; center mode turns around at the ends
   always @* begin
      count_d = count_q;
      dirDown_d = dirDown_q;
      wrapEvt = 1'b0;
      if (cpwm_q) begin
         if (!dirDown_q) begin
            if (atTop) begin
               dirDown_d = 1'b1;
               count_d = count_q - 16'h0001;
            end else begin
               count_d = count_q + 16'h0001;
            end
         end else begin
            if (count_q == 16'h0000) begin
               dirDown_d = 1'b0;
               wrapEvt = 1'b1;
               count_d = 16'h0001;
            end else begin
               count_d = count_q - 16'h0001;
            end
         end
      end else begin
         dirDown_d = 1'b0;
         if (atTop) begin
            count_d = 16'h0000;
            wrapEvt = 1'b1;
         end else begin
            count_d = count_q + 16'h0001;
         end
      end
   end

   // Modulo takes the buffer on the step into the old top value
   wire stepToTop = countEn & ~dirDown_d & (count_d == topVal) &
      (count_d != count_q);
   wire modXfer = modPending & stepToTop & (clkSel_q != `TMRC_CLK_NONE);
   // Half-written modulo blocks the flag
   wire ovfEvt = countEn & wrapEvt & ~(modGotH_q ^ modGotL_q);

   // Counter register; any counter write clears it whatever the data
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= `TMRC_CNT_RESET;
         dirDown_q <= 1'b0;
      end else if (cntWr) begin
         count_q <= `TMRC_CNT_RESET;
         dirDown_q <= 1'b0;
      end else if (countEn) begin
         count_q <= count_d;
         dirDown_q <= dirDown_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status/control register and overflow flag

   // Write zero clears only after a read saw the flag set
   // The arm bit is the first half of the two-step clear; any new
   // overflow drops it so software must read the flag once more.
   wire clrReq = scWr & ~pwdata[`TMRC_SC_OVF] & ovfArmed_q;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ovfFlag_q <= 1'b0;
         ovfArmed_q <= 1'b0;
         ovfIrqEn_q <= 1'b0;
         cpwm_q <= 1'b0;
         clkSel_q <= 2'h0;
         psSel_q <= 3'h0;
      end else begin
         // New overflow wins and disarms the clear
         if (ovfEvt) begin
            ovfFlag_q <= 1'b1;
            ovfArmed_q <= 1'b0;
         end else if (clrReq) begin
            ovfFlag_q <= 1'b0; // Writing one does nothing
            ovfArmed_q <= 1'b0;
         end else if (rdStb && hitSc && ovfFlag_q) begin
            ovfArmed_q <= 1'b1;
         end
         if (scWr) begin
            ovfIrqEn_q <= pwdata[`TMRC_SC_OVIE];
            cpwm_q <= pwdata[`TMRC_SC_CPWM];
            clkSel_q <= pwdata[`TMRC_SC_CLKS_HI:`TMRC_SC_CLKS_LO];
            psSel_q <= pwdata[`TMRC_SC_PS_HI:`TMRC_SC_PS_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter read coherency latch

   // Count captured at the setup edge of a counter read, the same edge
   // that registers the read data, so the latched word matches the byte
   // the bus returned even when the counter moves during the access
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cntSnap_q <= 16'h0000;
      end else if (psel && !penable && !pwrite) begin
         cntSnap_q <= count_q;
      end
   end

   // First byte read snapshots both; reads in debug leave the state machine alone
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdLatch_q <= 16'h0000;
         rdLatched_q <= 1'b0;
         rdGotH_q <= 1'b0;
      end else if (scWr || cntWr) begin
         rdLatched_q <= 1'b0;
      end else if (cntRd && run) begin
         if (!rdLatched_q) begin
            rdLatch_q <= cntSnap_q;
            rdLatched_q <= 1'b1;
            rdGotH_q <= hitCntH;
         end else if (rdGotH_q != hitCntH) begin
            rdLatched_q <= 1'b0;
         end
      end
   end

   wire [15:0] cntView = rdLatched_q ? rdLatch_q : count_q;

   ////////////////////////////////////////////////////////////////////////
   // Modulo buffer and write latch

   // Buffered update unless stopped or halted in debug
   // A control write always restarts the pair, even in debug. While
   // halted the pending-byte bits are left alone so a pair begun before
   // the halt still completes after it.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mod_q <= `TMRC_MOD_RESET;
         modBuf_q <= `TMRC_MOD_RESET;
         modGotH_q <= 1'b0;
         modGotL_q <= 1'b0;
      end else if (scWr) begin
         modGotH_q <= 1'b0;
         modGotL_q <= 1'b0;
      end else if (!run) begin
         // Debug writes go straight in, latch state held
         if (modWrH) begin
            mod_q[15:8] <= pwdata[7:0];
         end
         if (modWrL) begin
            mod_q[7:0] <= pwdata[7:0];
         end
      end else begin
         if (modWrH) begin
            modBuf_q[15:8] <= pwdata[7:0];
         end
         if (modWrL) begin
            modBuf_q[7:0] <= pwdata[7:0];
         end
         if ((modWrH | modGotH_q) && (modWrL | modGotL_q) &&
            (clkSel_q == `TMRC_CLK_NONE)) begin
            // Stopped clock copies at the second byte
            mod_q <= {modWrH ? pwdata[7:0] : modBuf_q[15:8],
               modWrL ? pwdata[7:0] : modBuf_q[7:0]};
            modGotH_q <= 1'b0;
            modGotL_q <= 1'b0;
         end else if (modXfer) begin
            mod_q <= modBuf_q;
            modGotH_q <= 1'b0;
            modGotL_q <= 1'b0;
         end else begin
            modGotH_q <= modGotH_q | modWrH;
            modGotL_q <= modGotL_q | modWrL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data mux, registered so data holds after the access

   reg [7:0] rdByte;
   always @* begin
      rdByte = 8'h00;
      if (hitSc) begin
         rdByte = {ovfFlag_q, ovfIrqEn_q, cpwm_q, clkSel_q, psSel_q};
      end else if (hitCntH) begin
         rdByte = cntView[15:8];
      end else if (hitCntL) begin
         rdByte = cntView[7:0];
      end else if (hitModH) begin
         rdByte = mod_q[15:8];
      end else if (hitModL) begin
         rdByte = mod_q[7:0];
      end
   end

   // Data presented in setup phase so it is valid when pready samples
   // Read side effects (flag arm, counter latch) act in the access phase
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rdByte};
      end
   end

endmodule // tmrc_timer_counter_regs

// ==== tmrc_timer_counter_regs_sva.sv ====
`timescale 1ns/100ps
`include "tmrc_regs.vh"
module tmrc_timer_counter_regs_sva (
   // Clock, reset and bus
   input wire ref_clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   // Timer side
   input wire fixedFreqClock,
   input wire externalCountClock,
   input wire debugHaltMode,
   input wire overflowIrq,
   input wire [15:0] counterValue,
   input wire countingDown,
   input wire centerAlignSelect
);
   // Completed writes, decoded once
   wire acc = psel && penable && pready;
   wire wrSc = acc && pwrite && paddr == `TMRC_ADDR_SC;
   wire wrCnt = acc && pwrite && (paddr == `TMRC_ADDR_CNTH ||
      paddr == `TMRC_ADDR_CNTL);
   wire mapped = paddr <= `TMRC_ADDR_MODL && paddr[1:0] == 2'h0;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   a_cnt_clear: assert property (wrCnt |=> counterValue == 16'h0000)
      else $error("counter not cleared by write");
   a_ctrl_center: assert property (wrSc |=>
      centerAlignSelect == $past(pwdata[5])) else $error("center bit");
   a_irq_mask: assert property (wrSc && !pwdata[6] |=> !overflowIrq)
      else $error("irq while disabled");
   a_err_map: assert property (psel && penable |-> pslverr == !mapped)
      else $error("slave error decode");
   a_debug_freeze: assert property (debugHaltMode && $past(debugHaltMode)
      && !wrCnt |=> $stable(counterValue)) else $error("count in debug");
   a_up_step: assert property (!countingDown && !$past(countingDown) &&
      $changed(counterValue) && !$past(wrCnt) |-> counterValue == 16'h0000
      || counterValue == $past(counterValue) + 16'h0001)
      else $error("bad up step");
   a_down_center: assert property (!centerAlignSelect &&
      !$past(centerAlignSelect) |-> !countingDown) else $error("down");
   a_irq_wrap: assert property ($rose(overflowIrq) |-> $past(wrSc) ||
      counterValue <= 16'h0001) else $error("irq without wrap");
endmodule // tmrc_timer_counter_regs_sva

bind tmrc_timer_counter_regs tmrc_timer_counter_regs_sva
   i_tmrc_timer_counter_regs_sva (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .fixedFreqClock(fixedFreqClock), .externalCountClock(externalCountClock),
   .debugHaltMode(debugHaltMode), .overflowIrq(overflowIrq),
   .counterValue(counterValue), .countingDown(countingDown),
   .centerAlignSelect(centerAlignSelect));

// ==== tmrc_timer_counter_regs_tb.sv ====
`timescale 1ns/100ps
`include "tmrc_regs.vh"
module tmrc_timer_counter_regs_tb;
   reg ref_clk, reset_n, psel, penable, pwrite, debugHaltMode;
   reg fixedFreqClock, externalCountClock;
   reg [7:0] paddr, rdv;
   reg [31:0] pwdata;
   reg [2:0] slowDiv;
   reg err;
   wire pready, pslverr, overflowIrq, countingDown, centerAlignSelect;
   wire [31:0] prdata;
   wire [15:0] counterValue;
   integer numErrors, nChecks, s;
   tmrc_timer_counter_regs i_tmrc_timer_counter_regs (.ref_clk(ref_clk),
      .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .fixedFreqClock(fixedFreqClock),
      .externalCountClock(externalCountClock), .debugHaltMode(debugHaltMode),
      .overflowIrq(overflowIrq), .counterValue(counterValue),
      .countingDown(countingDown), .centerAlignSelect(centerAlignSelect));
   ////////////////////////////////////////////////////////////////////////
   // Bus clock, then slow count clocks at an eighth of it
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      slowDiv <= slowDiv + 3'h1;
      fixedFreqClock <= slowDiv[2];
      externalCountClock <= slowDiv[2] ^ slowDiv[1];
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] g, input [31:0] e, input [31:0] tol);
      begin
         nChecks = nChecks + 1;
         if (^g === 1'bx || g > e + tol || g + tol < e) begin
            numErrors = numErrors + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   // One transfer; release costs an idle edge so no signal is set twice
   task xfer(input [7:0] a, input w, input [7:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h0, d};
         @(posedge ref_clk);
         penable <= 1'b1;
         do @(posedge ref_clk); while (pready !== 1'b1);
         rdv = prdata[7:0];
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rd(input [7:0] a);
      xfer(a, 1'b0, 8'h00);
   endtask
   task waitFor(input integer which);
      integer i;
      begin
         for (i = 0; i < 1000; i = i + 1) begin
            if ((which ? countingDown : overflowIrq) !== 1'b1) begin
               @(posedge ref_clk);
            end
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task tReset;
      begin
         rd(`TMRC_ADDR_SC);
         chk(rdv, 8'h00, 0);
         rd(`TMRC_ADDR_MODH);
         chk(rdv, 8'h00, 0);
         rd(`TMRC_ADDR_CNTL);
         chk(rdv, 8'h00, 0);
         rd(`TMRC_ADDR_CNTH);
         rd(8'h14);
         chk({err, rdv}, 9'h100, 0);
      end
   endtask
   // Overflow flag set, clear sequence, masked flag, half modulo write
   task tOverflow;
      begin
         wr(`TMRC_ADDR_CNTL, 8'h00);
         wr(`TMRC_ADDR_MODH, 8'h00);
         wr(`TMRC_ADDR_MODL, 8'h05);
         rd(`TMRC_ADDR_MODL);
         chk(rdv, 8'h05, 0);
         wr(`TMRC_ADDR_CNTL, 8'h00);
         wr(`TMRC_ADDR_SC, 8'h4f);
         waitFor(0);
         chk(overflowIrq, 1, 0);
         rd(`TMRC_ADDR_SC);
         chk(rdv, 8'hcf, 0);
         wr(`TMRC_ADDR_SC, 8'h4f);
         rd(`TMRC_ADDR_SC);
         chk(rdv, 8'h4f, 0);
         wr(`TMRC_ADDR_SC, 8'hcf);
         rd(`TMRC_ADDR_SC);
         chk(rdv, 8'h4f, 0);
         wr(`TMRC_ADDR_MODH, 8'h00);
         repeat (800) @(posedge ref_clk);
         chk(overflowIrq, 0, 0);
         wr(`TMRC_ADDR_MODL, 8'h05);
         waitFor(0);
         wr(`TMRC_ADDR_SC, 8'h0f);
         rd(`TMRC_ADDR_SC);
         chk({overflowIrq, rdv}, 9'h08f, 0);
      end
   endtask
   // Latched byte survives 300 counts; a control write drops the latch
   task tCoherent;
      begin
         wr(`TMRC_ADDR_SC, 8'h00);
         wr(`TMRC_ADDR_MODH, 8'h00);
         wr(`TMRC_ADDR_MODL, 8'h00);
         wr(`TMRC_ADDR_CNTL, 8'h00);
         wr(`TMRC_ADDR_SC, 8'h08);
         rd(`TMRC_ADDR_CNTL);
         chk(rdv, 8'h03, 3);
         repeat (300) @(posedge ref_clk);
         rd(`TMRC_ADDR_CNTH);
         chk(rdv, 8'h00, 0);
         wr(`TMRC_ADDR_SC, 8'h08);
         repeat (300) @(posedge ref_clk);
         rd(`TMRC_ADDR_CNTH);
         chk(rdv, 8'h02, 0);
         rd(`TMRC_ADDR_CNTL);
      end
   endtask
   // Every clock source; bus source divided by 8 to match the slow ones
   task tSources;
      for (s = 0; s < 4; s = s + 1) begin
         wr(`TMRC_ADDR_SC, {3'h0, s[1:0], (s == 1) ? 3'h3 : 3'h0});
         wr(`TMRC_ADDR_CNTH, 8'h5a);
         repeat (96) @(posedge ref_clk);
         rd(`TMRC_ADDR_CNTL);
         chk(rdv, (s == 0) ? 0 : 12, 2);
         rd(`TMRC_ADDR_CNTH);
      end
   endtask
   task tDebug;
      begin
         wr(`TMRC_ADDR_SC, 8'h08);
         wr(`TMRC_ADDR_CNTL, 8'h00);
         rd(`TMRC_ADDR_CNTL);
         repeat (300) @(posedge ref_clk);
         debugHaltMode <= 1'b1;
         @(posedge ref_clk);
         rd(`TMRC_ADDR_CNTH);
         wr(`TMRC_ADDR_MODH, 8'h12);
         rd(`TMRC_ADDR_MODH);
         chk(rdv, 8'h12, 0);
         debugHaltMode <= 1'b0;
         @(posedge ref_clk);
         rd(`TMRC_ADDR_CNTH);
         chk(rdv, 8'h00, 0);
      end
   endtask
   task tCenter;
      begin
         wr(`TMRC_ADDR_SC, 8'h00);
         wr(`TMRC_ADDR_MODH, 8'h00);
         wr(`TMRC_ADDR_MODL, 8'h05);
         wr(`TMRC_ADDR_CNTL, 8'h00);
         wr(`TMRC_ADDR_SC, 8'h28);
         waitFor(1);
         chk(countingDown, 1, 0);
         wr(`TMRC_ADDR_SC, 8'h00);
      end
   endtask
   task endOfTest;
      begin
         $display("Checks %0d errors %0d", nChecks, numErrors);
         if (numErrors == 0 && nChecks > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Whole run needs about 3800 cycles; five times that means a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      numErrors = numErrors + 1;
      endOfTest;
   end
   initial begin
      {reset_n, psel, penable, pwrite, debugHaltMode} = 5'h00;
      {fixedFreqClock, externalCountClock, slowDiv} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      numErrors = 0;
      nChecks = 0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      tReset;
      tOverflow;
      tCoherent;
      tSources;
      tDebug;
      tCenter;
      endOfTest;
   end
endmodule // tmrc_timer_counter_regs_tb
